/* logic/stn_lcd_pixel_output.sv */
// Pixel output path for a monochrome dual or single STN panel.
// Assumes timing syncs and DMA answers come from logic on ref_clk_in.
`timescale 1ns/1ps
module stn_lcd_pixel_output #(
  parameter int PIX_DIV = 3, // Clock cycles per pixel.
  parameter int LINE_W = 10 // Line and column counter width.
) (
  input wire logic ref_clk_in, // System clock.
  input wire logic srst_in, // Synchronous reset, high.
  input wire logic clk_en_in, // Freezes all state when low.
  input wire logic [stn_lcd_pkg::ADDR_W-1:0] reg_addr_in, // Register address.
  input wire logic [stn_lcd_pkg::DATA_W-1:0] reg_wdata_in, // Write data.
  input wire logic reg_wr_in, // Write strobe.
  input wire logic reg_rd_in, // Read strobe.
  output logic [stn_lcd_pkg::DATA_W-1:0] reg_rdata_out, // Read data.
  input wire logic disp_active_in, // Active pixel region.
  input wire logic hsync_in, // Line sync.
  input wire logic vsync_in, // Frame sync.
  output logic screen_req_out, // Screen quad-word request.
  input wire logic screen_ack_in, // Screen word delivered.
  input wire logic [stn_lcd_pkg::QW_W-1:0] screen_data_in, // Screen quad-word.
  output logic cursor_req_out, // Cursor quad-word request.
  input wire logic cursor_ack_in, // Cursor word delivered.
  input wire logic [stn_lcd_pkg::QW_W-1:0] cursor_data_in, // Cursor quad-word.
  output logic [7:0] panel_data_port_out, // Panel data byte.
  output logic panel_shift_clock_out, // Pixel-group clock.
  output logic panel_frame_out, // Frame pulse to panel.
  output logic panel_load_out, // Line load to panel.
  output logic lcd_enable_out, // Output path enabled.
  output logic dac_off_out // Colour converter off.
);
  import stn_lcd_pkg::*;

  localparam int DIV_W = $clog2(PIX_DIV + 1);

  if (PIX_DIV < 1 || LINE_W < 6 || LINE_W > 16) begin : g_bad_param
    $error("Unsupported divider or counter width");
  end

  function automatic logic grey_bit(input logic [3:0] lvl, input logic [3:0] frm, input logic en);
    // Level L is on in L of every 15 frames, so 0 never and 15 always.
    return en ? (lvl > frm) : lvl[3]; // RL4 RL5 RL6 RL21
  endfunction

  function automatic logic cur_vis(input logic [LINE_W-1:0] l, input logic lower,
                                   input logic [LINE_W-1:0] s, input logic [LINE_W-1:0] e,
                                   input logic strad, input logic low_sel);
    if (strad) begin
      return lower ? (l <= s) : (l >= e); // RL17
    end
    return (lower == low_sel) && (l >= s) && (l <= e);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [LINE_W-1:0] cs_q, cs_d, cend_q, cend_d, cx_q, cx_d;
  logic [3:0] green_q [0:15];
  logic [3:0] green_d [0:15];
  logic [3:0] ext_q [0:15];
  logic [3:0] ext_d [0:15];
  logic [3:0] red_q [0:15];
  logic [3:0] red_d [0:15];
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic underrun_q, underrun_d;
  logic [LINE_W-1:0] line_q, line_d;
  logic [3:0] frame_q, frame_d;
  logic [3:0] ridx;
  logic [1:0] src;
  logic run, dual;

  assign ridx = reg_addr_in[5:2];
  assign src = ctrl_q[CTRL_SRC_LSB +: 2];
  assign run = ctrl_q[CTRL_LCD_EN];
  assign dual = ctrl_q[CTRL_DUAL];

  always_comb begin
    ctrl_d = ctrl_q;
    cs_d = cs_q;
    cend_d = cend_q;
    cx_d = cx_q;
    green_d = green_q;
    ext_d = ext_q;
    red_d = red_q;
    rdata_d = '0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        OFS_CTRL: ctrl_d = reg_wdata_in[CTRL_W-1:0];
        OFS_CUR_START: cs_d = reg_wdata_in[LINE_W-1:0];
        OFS_CUR_END: cend_d = reg_wdata_in[LINE_W-1:0];
        OFS_CUR_X: cx_d = reg_wdata_in[LINE_W-1:0];
        default: begin
          if (reg_addr_in[1:0] == 2'b00) begin
            case (reg_addr_in[7:6])
              LUT_GREEN: green_d[ridx] = reg_wdata_in[3:0];
              LUT_EXT: ext_d[ridx] = reg_wdata_in[3:0];
              LUT_RED: red_d[ridx] = reg_wdata_in[3:0];
              default: ;
            endcase
          end
        end
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        OFS_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
        OFS_CUR_START: rdata_d[LINE_W-1:0] = cs_q;
        OFS_CUR_END: rdata_d[LINE_W-1:0] = cend_q;
        OFS_CUR_X: rdata_d[LINE_W-1:0] = cx_q;
        OFS_STATUS: begin
          rdata_d[STAT_UNDERRUN] = underrun_q;
          rdata_d[STAT_FRAME_LSB +: 4] = frame_q;
          rdata_d[STAT_LINE_LSB +: LINE_W] = line_q;
        end
        default: begin
          if (reg_addr_in[1:0] == 2'b00) begin
            case (reg_addr_in[7:6])
              LUT_GREEN: rdata_d[3:0] = green_q[ridx];
              LUT_EXT: rdata_d[3:0] = ext_q[ridx];
              LUT_RED: rdata_d[3:0] = red_q[ridx];
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctrl_q <= CTRL_RST;
      cs_q <= '0;
      cend_q <= '0;
      cx_q <= '0;
      rdata_q <= '0;
      for (int i = 0; i < GREY_LEVELS; i++) begin
        green_q[i] <= '0;
        ext_q[i] <= '0;
        red_q[i] <= '0;
      end
    end else if (clk_en_in) begin
      ctrl_q <= ctrl_d;
      cs_q <= cs_d;
      cend_q <= cend_d;
      cx_q <= cx_d;
      rdata_q <= rdata_d;
      green_q <= green_d;
      ext_q <= ext_d;
      red_q <= red_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign lcd_enable_out = run; // RL20
  assign dac_off_out = ctrl_q[CTRL_DAC_OFF]; // RL20

  ////////////////////////////////////////////////////////////////////////////
  // Fetch engine, raster counters and pixel output.

  fetch_e fst_q, fst_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [1:0] ph_q, ph_d;
  logic [LINE_W-1:0] x_q, x_d;
  logic [4:0] pix_q, pix_d;
  logic [QW_W-1:0] cur_up_q, cur_up_d, cur_lo_q, cur_lo_d;
  logic [QW_W-1:0] nxt_up_q, nxt_up_d, nxt_lo_q, nxt_lo_d, cbuf_q, cbuf_d;
  logic nxt_valid_q, nxt_valid_d, cur_valid_q, cur_valid_d;
  logic cur_need_q, cur_need_d, hs_q, vs_q;
  logic [7:0] data_q, data_d;
  logic sclk_q, sclk_d;
  logic tick, grp, hs_rise, vs_rise;

  assign tick = (div_q == DIV_W'(PIX_DIV - 1));
  assign grp = tick && (ph_q == 2'b00) && disp_active_in && run;
  assign hs_rise = hsync_in && !hs_q;
  assign vs_rise = vsync_in && !vs_q;

  always_comb begin
    logic [3:0] up_lvl;
    logic [3:0] lo_lvl;
    logic [3:0] lo_map;
    logic [4:0] idx;
    logic [LINE_W-1:0] cxo;
    logic [LINE_W-1:0] nl;
    logic [63:0] crow;
    logic [1:0] code;
    logic fill;
    up_lvl = '0;
    lo_lvl = '0;
    lo_map = '0;
    idx = '0;
    cxo = '0;
    nl = line_q + 1'b1;
    crow = line_q[0] ? cbuf_q[127:64] : cbuf_q[63:0];
    code = '0;
    fill = 1'b0;
    fst_d = fst_q;
    div_d = tick ? '0 : div_q + 1'b1;
    ph_d = ph_q;
    x_d = x_q;
    pix_d = pix_q;
    line_d = line_q;
    frame_d = frame_q;
    cur_up_d = cur_up_q;
    cur_lo_d = cur_lo_q;
    nxt_up_d = nxt_up_q;
    nxt_lo_d = nxt_lo_q;
    nxt_valid_d = nxt_valid_q;
    cur_valid_d = cur_valid_q;
    cbuf_d = cbuf_q;
    cur_need_d = cur_need_q;
    underrun_d = underrun_q;
    data_d = data_q;
    sclk_d = sclk_q;
    case (fst_q)
      F_IDLE: begin
        if (cur_need_q) begin
          fst_d = F_CUR;
        end else if (!nxt_valid_q && run) begin
          fst_d = F_UP; // RL1
        end
      end
      F_UP: begin
        if (screen_ack_in) begin
          nxt_up_d = screen_data_in; // RL2
          fill = !dual;
          fst_d = dual ? F_LO : F_IDLE; // RL8
        end
      end
      F_LO: begin
        if (screen_ack_in) begin
          nxt_lo_d = screen_data_in; // RL2 RL8
          fill = 1'b1;
          fst_d = F_IDLE;
        end
      end
      F_CUR: begin
        if (cursor_ack_in) begin
          cbuf_d = cursor_data_in; // RL2 RL15
          cur_need_d = 1'b0;
          fst_d = F_IDLE;
        end
      end
      default: fst_d = F_IDLE;
    endcase
    if (tick && disp_active_in && run) begin
      ph_d = ph_q + 2'b01;
    end
    if (grp) begin
      for (int k = 0; k < GROUP_PIXELS; k++) begin
        idx = pix_q + 5'(k);
        up_lvl = cur_up_q[{idx, 2'b00} +: 4]; // RL7
        lo_lvl = cur_lo_q[{idx, 2'b00} +: 4]; // RL7
        cxo = x_q + LINE_W'(k) - cx_q;
        code = crow[{cxo[4:0], 1'b0} +: 2];
        // Cursor codes 1..3 reuse the first lookup entries; 0 is transparent.
        if (cxo < LINE_W'(CUR_WIDTH) && code != 2'b00) begin
          if (cur_vis(line_q, 1'b0, cs_q, cend_q, ctrl_q[CTRL_STRADDLE], ctrl_q[CTRL_CUR_LOWER])) begin
            up_lvl = {2'b00, code}; // RL14
          end
          if (cur_vis(line_q, 1'b1, cs_q, cend_q, ctrl_q[CTRL_STRADDLE], ctrl_q[CTRL_CUR_LOWER])) begin
            lo_lvl = {2'b00, code}; // RL14 RL17
          end
        end
        case (src)
          SRC_GREEN: lo_map = green_q[lo_lvl]; // RL3
          SRC_RED_GREEN: lo_map = red_q[lo_lvl]; // RL3
          default: lo_map = ext_q[lo_lvl]; // RL3 RL10
        endcase
        data_d[7 - k] = cur_valid_q && grey_bit(green_q[up_lvl], frame_q, ctrl_q[CTRL_GREY_EN]); // RL9 RL10
        data_d[3 - k] = cur_valid_q && dual && grey_bit(lo_map, frame_q, ctrl_q[CTRL_GREY_EN]); // RL9 RL11
      end
      x_d = x_q + LINE_W'(GROUP_PIXELS);
      pix_d = pix_q + 5'(GROUP_PIXELS);
      if (pix_q == QW_LAST_GRP) begin
        cur_valid_d = nxt_valid_q;
        nxt_valid_d = 1'b0;
        cur_up_d = nxt_up_q;
        cur_lo_d = nxt_lo_q;
      end
    end
    if (fill) begin
      nxt_valid_d = 1'b1;
    end
    if (reg_wr_in && reg_addr_in == OFS_STATUS && reg_wdata_in[STAT_UNDERRUN]) begin
      underrun_d = 1'b0;
    end
    if (grp && pix_q == QW_LAST_GRP && !nxt_valid_q) begin
      underrun_d = 1'b1;
    end
    if (!run || !ctrl_q[CTRL_SCLK_SEL] || !disp_active_in) begin
      sclk_d = 1'b0;
    end else if (grp) begin
      sclk_d = 1'b1; // RL12
    end else if (tick && ph_q == 2'b10) begin
      sclk_d = 1'b0; // RL12
    end
    if (!disp_active_in) begin
      ph_d = '0;
    end
    if (vs_rise) begin
      frame_d = (frame_q == FRAME_LAST) ? 4'h0 : frame_q + 4'h1; // RL21
      line_d = '1;
    end else if (hs_rise) begin
      line_d = nl;
      x_d = '0;
      ph_d = '0;
      // A fetch on an even raster serves it and the odd raster after it.
      if (!nl[0] && (cur_vis(nl, 1'b0, cs_q, cend_q, ctrl_q[CTRL_STRADDLE], ctrl_q[CTRL_CUR_LOWER])
          || cur_vis(nl, 1'b1, cs_q, cend_q, ctrl_q[CTRL_STRADDLE], ctrl_q[CTRL_CUR_LOWER])
          || cur_vis(nl + 1'b1, 1'b0, cs_q, cend_q, ctrl_q[CTRL_STRADDLE], ctrl_q[CTRL_CUR_LOWER])
          || cur_vis(nl + 1'b1, 1'b1, cs_q, cend_q, ctrl_q[CTRL_STRADDLE], ctrl_q[CTRL_CUR_LOWER]))) begin
        cur_need_d = 1'b1; // RL15 RL16
      end
    end
    // Blanking costs nothing here, so the panel sees zeros whenever forced or disabled.
    if (ctrl_q[CTRL_FORCE_ZERO] || !run) begin
      data_d = '0; // RL13
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      fst_q <= F_IDLE;
      div_q <= '0;
      ph_q <= '0;
      x_q <= '0;
      pix_q <= '0;
      line_q <= '0;
      frame_q <= '0;
      cur_up_q <= '0;
      cur_lo_q <= '0;
      nxt_up_q <= '0;
      nxt_lo_q <= '0;
      cbuf_q <= '0;
      nxt_valid_q <= 1'b0;
      cur_valid_q <= 1'b0;
      cur_need_q <= 1'b0;
      underrun_q <= 1'b0;
      hs_q <= 1'b0;
      vs_q <= 1'b0;
      data_q <= '0;
      sclk_q <= 1'b0;
    end else if (clk_en_in) begin
      fst_q <= fst_d;
      div_q <= div_d;
      ph_q <= ph_d;
      x_q <= x_d;
      pix_q <= pix_d;
      line_q <= line_d;
      frame_q <= frame_d;
      cur_up_q <= cur_up_d;
      cur_lo_q <= cur_lo_d;
      nxt_up_q <= nxt_up_d;
      nxt_lo_q <= nxt_lo_d;
      cbuf_q <= cbuf_d;
      nxt_valid_q <= nxt_valid_d;
      cur_valid_q <= cur_valid_d;
      cur_need_q <= cur_need_d;
      underrun_q <= underrun_d;
      hs_q <= hsync_in;
      vs_q <= vsync_in;
      data_q <= data_d;
      sclk_q <= sclk_d;
    end
  end

  assign screen_req_out = (fst_q == F_UP) || (fst_q == F_LO); // RL1
  assign cursor_req_out = (fst_q == F_CUR); // RL1
  assign panel_data_port_out = data_q;
  assign panel_shift_clock_out = sclk_q;
  assign panel_frame_out = vs_q;
  assign panel_load_out = hs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_up_done;
    fst_q == F_UP && screen_ack_in && clk_en_in;
  endsequence

  chk_dual_alt: assert property (s_up_done and dual |=> fst_q == F_LO) // RL8
    else $error("Dual fetch did not move to lower half");
  chk_single_fill: assert property (s_up_done and !dual |=> nxt_valid_q && fst_q == F_IDLE) // RL2
    else $error("Single fetch did not fill buffer");
  chk_req_excl: assert property (!(screen_req_out && cursor_req_out)) // RL1
    else $error("Screen and cursor requested together");
  chk_force_zero: assert property (clk_en_in && ctrl_q[CTRL_FORCE_ZERO] |=> panel_data_port_out == 8'h00) // RL13
    else $error("Data port not forced to zero");
  chk_single_low: assert property (grp && clk_en_in && !dual |=> panel_data_port_out[3:0] == 4'h0) // RL11
    else $error("Single panel drove lower nibble");
  chk_sclk_rise: assert property (grp && clk_en_in && ctrl_q[CTRL_SCLK_SEL] |=> panel_shift_clock_out) // RL12
    else $error("Shift clock not high at group start");
  chk_sclk_fall: assert property (tick && clk_en_in && ph_q == 2'b10 |=> !panel_shift_clock_out) // RL12
    else $error("Shift clock not low at mid group");
  chk_frame_range: assert property (frame_q <= FRAME_LAST) // RL21
    else $error("Frame counter out of range");
  chk_frame_step: assert property (vs_rise && clk_en_in && frame_q != FRAME_LAST |=> frame_q == $past(frame_q) + 4'h1) // RL21
    else $error("Frame counter did not advance");
  chk_cur_even: assert property ($rose(cur_need_q) |-> !line_q[0]) // RL16
    else $error("Cursor fetch armed on odd raster");
endmodule // stn_lcd_pixel_output

/* common/stn_lcd_pkg.sv */
// Shared constants for the monochrome STN pixel output path.
// Assumes one clock domain and register access over a plain strobe port.
// Notes on behaviour
// RL1 - Separate request lines fetch screen words and cursor words on demand.
// RL2 - Each served request delivers one whole quad-word block.
// RL3 - Source select field picks green, red plus green, or green plus external lookups.
// RL4 - Grey scaler works frame by frame on green and external lookup values.
// RL5 - Scaler always has sixteen levels; fewer bits per pixel use palette mapping.
// RL6 - Each 4-bit level becomes one pulse-width modulated output bit.
// RL7 - A quad-word holds 32 pixels, one 4-bit level per nibble.
// RL8 - Dual panel fetches alternate upper and lower quad-words.
// RL9 - Dual byte: lower half pixels on bits 0 to 3, upper half on 4 to 7.
// RL10 - Upper pixels map through green lookup, lower through external lookup.
// RL11 - Single panel drives pixel data on the upper nibble only.
// RL12 - Shift clock runs at a quarter of pixel rate, four pixels per clock period.
// RL13 - Data port can be forced to zero around panel power changes.
// RL14 - Cursor is 32 pixels wide, 2 bits each, any height, same pixel path.
// RL15 - One cursor quad-word is fetched every second raster where the cursor shows.
// RL16 - Cursor fetches sit on even rasters; odd starts need a shifted image.
// RL17 - Straddle mode shows cursor from lower raster 0 to start, upper from end.
// RL18 - Software stores a doubled image for a cursor straddling the join.
// RL19 - Software adds offset copies for odd starts, four images in all.
// RL20 - Control can enable the output path, turn off converters, select shift clock.
// RL21 - A frame counter makes on-frames rise with level; 0 off, 15 on.
package stn_lcd_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int QW_W = 128;
  localparam int CTRL_W = 10;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CUR_START = 8'h04;
  localparam logic [7:0] OFS_CUR_END = 8'h08;
  localparam logic [7:0] OFS_CUR_X = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [1:0] LUT_GREEN = 2'h1;
  localparam logic [1:0] LUT_EXT = 2'h2;
  localparam logic [1:0] LUT_RED = 2'h3;
  localparam int CTRL_LCD_EN = 0;
  localparam int CTRL_DAC_OFF = 1;
  localparam int CTRL_SCLK_SEL = 2;
  localparam int CTRL_FORCE_ZERO = 3;
  localparam int CTRL_GREY_EN = 4;
  localparam int CTRL_DUAL = 5;
  localparam int CTRL_STRADDLE = 6;
  localparam int CTRL_CUR_LOWER = 7;
  localparam int CTRL_SRC_LSB = 8;
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h008;
  localparam int STAT_UNDERRUN = 0;
  localparam int STAT_FRAME_LSB = 4;
  localparam int STAT_LINE_LSB = 16;
  localparam logic [1:0] SRC_GREEN = 2'h0;
  localparam logic [1:0] SRC_RED_GREEN = 2'h1;
  localparam logic [1:0] SRC_GREEN_EXT = 2'h2;
  localparam int GREY_LEVELS = 16;
  localparam logic [3:0] FRAME_LAST = 4'hE;
  localparam int GROUP_PIXELS = 4;
  localparam logic [4:0] QW_LAST_GRP = 5'h1C;
  localparam int CUR_WIDTH = 32;
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_UP = 2'b01,
    F_LO = 2'b11,
    F_CUR = 2'b10
  } fetch_e;
endpackage

/* tb/stn_panel_model.sv */
// Passive panel model: latches the data byte at each rising shift clock edge.
// Assumes the shift clock and the data byte are both registered on ref_clk_in.
`timescale 1ns/1ps
module stn_panel_model (
  input wire logic ref_clk_in, // System clock.
  input wire logic [7:0] panel_data_port_in, // Panel data byte.
  input wire logic panel_shift_clock_in, // Pixel-group clock.
  output logic [7:0] last_byte_out, // Byte taken at the last edge.
  output int edge_count_out, // Rising edges seen.
  output int period_out // Clocks between the last two edges.
);
  logic sclk_q = 1'b0;
  int cyc_q = 0;
  int mark_q = 0;
  initial begin
    last_byte_out = 8'h00;
    edge_count_out = 0;
    period_out = 0;
  end
  // The panel shifts on the rising edge, so the byte must already be valid there.
  always @(posedge ref_clk_in) begin
    sclk_q <= panel_shift_clock_in;
    cyc_q <= cyc_q + 1;
    if (panel_shift_clock_in && !sclk_q) begin
      last_byte_out <= panel_data_port_in;
      edge_count_out <= edge_count_out + 1;
      period_out <= cyc_q - mark_q;
      mark_q <= cyc_q;
    end
  end
endmodule // stn_panel_model

/* tb/tb_stn_lcd_pixel_output.sv */
// Self-checking bench for the STN pixel output path, with DMA responder and panel model.
// Assumes the design package is compiled first; all stimulus is on ref_clk_in.
`timescale 1ns/1ps
module tb_stn_lcd_pixel_output;
  import stn_lcd_pkg::*;
  localparam int PIX = 3;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic disp = 1'b0;
  logic hs = 1'b0;
  logic vs = 1'b0;
  logic sreq;
  logic sack = 1'b0;
  logic [QW_W-1:0] sdata = '0;
  logic creq;
  logic cack = 1'b0;
  logic [QW_W-1:0] cdata = '0;
  logic [7:0] pdata;
  logic sclk;
  logic lcd_en;
  logic dac_off;
  logic pframe;
  logic pload;
  logic hold = 1'b0;
  logic [QW_W-1:0] up_w = '0;
  logic [QW_W-1:0] lo_w = '0;
  logic lo_next = 1'b0;
  logic dual_q = 1'b0;
  logic [7:0] last_byte;
  int edges;
  int period;
  int cur_cnt = 0;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  stn_lcd_pixel_output #(.PIX_DIV(PIX), .LINE_W(10)) i_dut (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .clk_en_in(clk_en_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .disp_active_in(disp), .hsync_in(hs), .vsync_in(vs),
    .screen_req_out(sreq), .screen_ack_in(sack), .screen_data_in(sdata),
    .cursor_req_out(creq), .cursor_ack_in(cack), .cursor_data_in(cdata),
    .panel_data_port_out(pdata), .panel_shift_clock_out(sclk), .panel_frame_out(pframe),
    .panel_load_out(pload), .lcd_enable_out(lcd_en), .dac_off_out(dac_off));

  stn_panel_model i_panel (.ref_clk_in(ref_clk_in), .panel_data_port_in(pdata),
    .panel_shift_clock_in(sclk), .last_byte_out(last_byte), .edge_count_out(edges), .period_out(period));

  ////////////////////////////////////////////////////////////////////////////////
  // DMA responder: acks one cycle after a request (hold stalls screen acks), alternating upper and lower words in dual mode, upper words only in single mode.
  always @(posedge ref_clk_in) begin
    if (srst_in) begin
      sack <= 1'b0;
      cack <= 1'b0;
      lo_next <= 1'b0;
    end else begin
      sack <= sreq && !sack && !hold;
      cack <= creq && !cack;
      if (sreq && !sack && !hold) begin
        sdata <= lo_next ? lo_w : up_w;
        lo_next <= dual_q && !lo_next;
      end
      if (creq && !cack) begin
        cur_cnt <= cur_cnt + 1;
        // Every row of the stored image is code 3, so the doubled and offset copies read alike.
        cdata <= '1;
      end
    end
  end

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic [31:0] ctrl(input bit dl, input bit grey, input bit frc, input bit rg = 1'b0);
    logic [1:0] src;
    src = rg ? SRC_RED_GREEN : (dl ? SRC_GREEN_EXT : SRC_GREEN);
    return (32'(1) << CTRL_LCD_EN) | (32'(1) << CTRL_SCLK_SEL) | (32'(frc) << CTRL_FORCE_ZERO) |
      (32'(grey) << CTRL_GREY_EN) | (32'(dl) << CTRL_DUAL) | (32'(src) << CTRL_SRC_LSB);
  endfunction

  // Green table is identity, the external table inverts and the red table holds 8, so the halves differ.
  function automatic logic [7:0] exp_byte(input bit dl, input bit grey, input int fr,
                                          input logic [3:0] a, input logic [3:0] b, input bit rg = 1'b0);
    logic [3:0] lo;
    logic on_u;
    logic on_l;
    lo = rg ? 4'h8 : 4'hF - b;
    on_u = grey ? (int'(a) > fr) : a[3];
    on_l = grey ? (int'(lo) > fr) : lo[3];
    return {{4{on_u}}, (dl ? {4{on_l}} : 4'h0)};
  endfunction

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic checki(input int got, input int exp);
    total_checks = total_checks + 1;
    if (got != exp) begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic start(input bit dl, input logic [31:0] c);
    @(posedge ref_clk_in);
    srst_in <= 1'b1;
    dual_q <= dl;
    repeat (6) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      wr_reg(8'h40 + 8'(4 * i), 32'(i));
      wr_reg(8'h80 + 8'(4 * i), 32'(15 - i));
      wr_reg(8'hC0 + 8'(4 * i), 32'h0000_0008);
    end
    wr_reg(OFS_CTRL, c);
  endtask

  task automatic line(input int groups);
    @(posedge ref_clk_in);
    hs <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    hs <= 1'b0;
    disp <= 1'b1;
    #1;
    check8({6'h0, pframe, pload}, 8'h01);
    repeat (groups * 4 * PIX) @(posedge ref_clk_in);
    disp <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
  endtask

  task automatic frame();
    @(posedge ref_clk_in);
    vs <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    vs <= 1'b0;
    #1;
    check8({6'h0, pframe, pload}, 8'h02);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [31:0] rnd;
    logic [3:0] a;
    logic [3:0] b;
    int e0;
    bit rg;
    rnd = 32'h0000_19d0;
    repeat (6) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    rd_reg(OFS_CTRL, d);
    check32(d, 32'(CTRL_RST));
    check8(pdata, 8'h00);
    wr_reg(OFS_CTRL, 32'h0000_03C7);
    rd_reg(OFS_CTRL, d);
    check32(d, 32'h0000_03C7);
    check32({30'h0, dac_off, lcd_en}, 32'h0000_0003);
    clk_en_in <= 1'b0;
    wr_reg(OFS_CTRL, 32'h0000_0000);
    clk_en_in <= 1'b1;
    rd_reg(OFS_CTRL, d);
    check32(d, 32'h0000_03C7);
    rd_reg(8'h14, d);
    check32(d, 32'h0000_0000);
    $display("test registers done");
    // Forced zeros with the shift clock still running, then the clock gated off.
    start(1'b1, ctrl(1'b1, 1'b0, 1'b1));
    line(32);
    line(32);
    check8(last_byte, 8'h00);
    checki(period, 4 * PIX);
    wr_reg(OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0) & ~(32'(1) << CTRL_SCLK_SEL));
    e0 = edges;
    line(8);
    checki(edges, e0);
    $display("test force zero done");
    for (int t = 0; t < 8; t++) begin
      rnd = xs(rnd);
      a = (t < 2) ? 4'(15 * t) : rnd[3:0];
      b = (t < 2) ? 4'(15 - 15 * t) : rnd[7:4];
      up_w = {32{a}};
      lo_w = {32{b}};
      rg = t[0] && (t > 3);
      start(t[0], ctrl(t[0], 1'b0, 1'b0, rg));
      line(32);
      line(32);
      check8(last_byte, exp_byte(t[0], 1'b0, 0, a, b, rg));
      checki(period, 4 * PIX);
    end
    $display("test pixel mapping done");
    up_w = {32{4'h8}};
    lo_w = {32{4'h0}};
    start(1'b1, ctrl(1'b1, 1'b1, 1'b0));
    line(32);
    for (int f = 1; f <= 15; f++) begin
      frame();
      line(32);
      check8(last_byte, exp_byte(1'b1, 1'b1, f % 15, 4'h8, 4'h0));
    end
    $display("test grey scale done");
    start(1'b1, ctrl(1'b1, 1'b0, 1'b0));
    wr_reg(OFS_CUR_START, 32'h0000_0002);
    wr_reg(OFS_CUR_END, 32'h0000_0005);
    e0 = cur_cnt;
    frame();
    repeat (4) line(8);
    check8(last_byte, exp_byte(1'b1, 1'b0, 0, 4'h3, 4'h0));
    repeat (4) line(8);
    checki(cur_cnt - e0, 2);
    wr_reg(OFS_CTRL, ctrl(1'b1, 1'b0, 1'b0) | (32'(1) << CTRL_STRADDLE));
    wr_reg(OFS_CUR_START, 32'h0000_0003);
    wr_reg(OFS_CUR_END, 32'h0000_0006);
    e0 = cur_cnt;
    frame();
    repeat (8) line(8);
    checki(cur_cnt - e0, 3);
    $display("test cursor fetch done");
    // Stalling screen acks leaves the next buffer empty at the second swap.
    hold <= 1'b1;
    repeat (2) line(8);
    rd_reg(OFS_STATUS, d);
    check32(d, (32'(9) << STAT_LINE_LSB) | (32'(2) << STAT_FRAME_LSB) | (32'(1) << STAT_UNDERRUN));
    hold <= 1'b0;
    wr_reg(OFS_STATUS, 32'(1) << STAT_UNDERRUN);
    rd_reg(OFS_STATUS, d);
    check32(d, (32'(9) << STAT_LINE_LSB) | (32'(2) << STAT_FRAME_LSB));
    $display("test status done");
    give_verdict();
  end
endmodule // tb_stn_lcd_pixel_output
